// >>> udp_pkg.sv
// Operation
// RL1 - 8-bit mode, no valid strobe: bus content is meaningless and ignored.
// RL2 - 8-bit mode receive: received byte appears on the upper lane.
// RL3 - 8-bit mode transmit: link controller drives the byte on the lower lane.
// RL4 - Rising transmit_valid starts a SYNC on the line before packet data.
// RL5 - Falling transmit_valid ends the packet with an EOP on the line.
// RL6 - Link controller keeps mode controls steady on transmit_valid edges.
// RL7 - Link controller changes mode controls only while the port is idle.
// RL8 - Link controller keeps the next transmit word ready once transmitting.
// RL9 - transmit_ready marks the edge where the transmit word is taken.
// RL10 - Link controller ignores transmit_ready while transmit_valid is low.
// RL11 - 16-bit transmit: controller drives bus and upper_byte_valid.
// RL12 - 16-bit receive: device drives bus and upper_byte_valid as outputs.
// RL13 - upper_byte_valid used only in 16-bit mode; device drives bus then.
// RL14 - receive_valid only when a received word is held for unloading.
// RL15 - Link controller captures receive data where receive_valid is high.
// RL16 - receive_active rises at packet start and holds while receiving.
// RL17 - receive_error flags a fault, timed exactly like the data bus.
// RL18 - A receive fault may show in any cycle of a transfer.
// RL19 - 16-bit receive with upper_byte_valid low: only low byte valid.
package udp_pkg;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] OE_ALL_IN = 16'hFFFF;
    localparam logic [15:0] OE_ALL_OUT = 16'h0000;
    localparam logic [15:0] OE_UPPER_OUT = 16'h00FF;
    localparam logic [1:0] NO_BYTES = 2'h0;
    localparam logic [1:0] ONE_BYTE = 2'h1;
    localparam logic [1:0] TWO_BYTES = 2'h2;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BYTE_TIME_NS = 800;
    localparam int BYTE_CLKS = (BYTE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (BYTE_TIME_NS / CLK_PERIOD_NS);
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_SYNC = 4'h2,
        TX_DATA = 4'h4,
        TX_EOP = 4'h8
    } udp_tx_state_t;
    typedef enum logic [1:0] {
        LINE_NONE = 2'h0,
        LINE_SYNC = 2'h1,
        LINE_DATA = 2'h2,
        LINE_EOP = 2'h3
    } udp_line_kind_t;
endpackage : udp_pkg

// >>> udp_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
interface udp_rx_if;
    logic word_valid;
    logic [15:0] word;
    logic upper_ok;
    logic active;
    logic error;
    modport packer (output word_valid, output word, output upper_ok, output active, output error);
    modport port (input word_valid, input word, input upper_ok, input active, input error);
endinterface : udp_rx_if
`default_nettype wire

// >>> udp_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module udp_tick_gen #(
    parameter int unsigned PERIOD = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic enable,
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    localparam logic [CW-1:0] CZERO = '0;
    logic [CW-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    always_comb begin
        cnt_d = CZERO;
        tick_d = 1'b0;
        if (enable) begin
            tick_d = (cnt_q == LAST);
            cnt_d = tick_d ? CZERO : cnt_q + CW'(1);
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= CZERO;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end
    assign tick = tick_q;
endmodule : udp_tick_gen
`default_nettype wire

// >>> udp_rx_packer.sv
`timescale 1ns/1ps
`default_nettype none
module udp_rx_packer (
    input wire logic clock,
    input wire logic nrst,
    input wire logic mode16,
    input wire logic line_rx_active,
    input wire logic line_rx_strobe,
    input wire logic [7:0] line_rx_byte,
    input wire logic line_rx_fault,
    udp_rx_if.packer rx
);
    import udp_pkg::*;
    logic [7:0] low_q, low_d;
    logic pend_q, pend_d;
    logic valid_q, valid_d;
    logic [15:0] word_q, word_d;
    logic upper_q, upper_d;
    logic active_q, active_d;
    logic error_q, error_d;
    always_comb begin
        low_d = low_q;
        pend_d = pend_q;
        valid_d = 1'b0;
        word_d = word_q;
        upper_d = 1'b0;
        active_d = line_rx_active; // see RL16
        error_d = line_rx_fault & (line_rx_active | active_q); // see RL17 see RL18
        if (line_rx_strobe && !mode16) begin
            valid_d = 1'b1; // see RL14
            word_d = {line_rx_byte, ZERO_BYTE}; // see RL2
        end else if (line_rx_strobe && !pend_q) begin
            low_d = line_rx_byte;
            pend_d = 1'b1;
        end else if (line_rx_strobe) begin
            valid_d = 1'b1;
            upper_d = 1'b1;
            word_d = {line_rx_byte, low_q};
            pend_d = 1'b0;
        end else if (pend_q && !line_rx_active) begin
            // Odd byte at packet end leaves with the upper half marked invalid
            valid_d = 1'b1;
            word_d = {ZERO_BYTE, low_q}; // see RL19
            pend_d = 1'b0;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_q <= ZERO_BYTE;
            pend_q <= 1'b0;
            valid_q <= 1'b0;
            word_q <= ZERO_WORD;
            upper_q <= 1'b0;
            active_q <= 1'b0;
            error_q <= 1'b0;
        end else begin
            low_q <= low_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
            word_q <= word_d;
            upper_q <= upper_d;
            active_q <= active_d;
            error_q <= error_d;
        end
    end
    assign rx.word_valid = valid_q;
    assign rx.word = word_q;
    assign rx.upper_ok = upper_q;
    // Stays up through the flush of an odd last byte so valid never leaves active
    assign rx.active = active_q | pend_q | valid_q; // see RL16
    assign rx.error = error_q;
endmodule : udp_rx_packer
`default_nettype wire

// >>> udp_port.sv
`timescale 1ns/1ps
`default_nettype none
module udp_port #(
    parameter int unsigned BYTE_CLKS_P = udp_pkg::BYTE_CLKS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bus_mode_16,
    input wire logic transmit_valid,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe_n,
    input wire logic upper_byte_valid_in,
    output logic upper_byte_valid_out,
    output logic upper_byte_valid_oe_n,
    output logic transmit_ready,
    output logic receive_valid,
    output logic receive_active,
    output logic receive_error,
    output udp_pkg::udp_line_kind_t line_tx_kind,
    output logic [7:0] line_tx_byte,
    output logic line_tx_strobe,
    input wire logic line_rx_active,
    input wire logic line_rx_strobe,
    input wire logic [7:0] line_rx_byte,
    input wire logic line_rx_fault
);
    import udp_pkg::*;

    udp_rx_if rx ();

    udp_tx_state_t state_q, state_d;
    logic mode_q, mode_d;
    logic tick;
    logic tick_run;
    logic idle;

    logic [15:0] hold_q, hold_d;
    logic [1:0] left_q, left_d;
    logic ready_q, ready_d;
    logic take;

    udp_line_kind_t kind_q, kind_d;
    logic [7:0] byte_q, byte_d;
    logic strobe_q, strobe_d;

    logic [15:0] dout_q, dout_d;
    logic [15:0] oe_n_q, oe_n_d;
    logic uout_q, uout_d;
    logic uoe_n_q, uoe_n_d;
    logic rvalid_q, rvalid_d;
    logic ractive_q, ractive_d;
    logic rerror_q, rerror_d;

    // Byte pacing toward the line; held in reset while idle so the
    // first SYNC byte always leaves a full byte time after the request
    assign tick_run = (state_q != TX_IDLE);

    udp_tick_gen #(
        .PERIOD(BYTE_CLKS_P)
    ) u_tick (
        .clock(clock),
        .nrst(nrst),
        .enable(tick_run),
        .tick(tick)
    );

    udp_rx_packer u_rx (
        .clock(clock),
        .nrst(nrst),
        .mode16(mode_q),
        .line_rx_active(line_rx_active),
        .line_rx_strobe(line_rx_strobe),
        .line_rx_byte(line_rx_byte),
        .line_rx_fault(line_rx_fault),
        .rx(rx.packer)
    );

    // Bus width is taken only while quiet; a change mid-packet would
    // tear a word, so it waits for the next idle cycle
    assign idle = (state_q == TX_IDLE) && !transmit_valid && !line_rx_active && !rx.active; // see RL7

    always_comb begin
        mode_d = mode_q;
        if (idle) begin
            mode_d = bus_mode_16; // see RL6
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Word is taken at the edge where transmit_ready stands high
    assign take = ready_q && transmit_valid && (state_q == TX_DATA); // see RL9

    always_comb begin
        state_d = state_q;
        kind_d = LINE_NONE;
        byte_d = ZERO_BYTE;
        strobe_d = 1'b0;
        hold_d = hold_q;
        left_d = left_q;
        ready_d = 1'b0;
        case (state_q)
            TX_IDLE: begin
                if (transmit_valid) begin
                    state_d = TX_SYNC; // see RL4
                end
            end
            TX_SYNC: begin
                if (tick) begin
                    kind_d = LINE_SYNC; // see RL4
                    strobe_d = 1'b1;
                    state_d = TX_DATA;
                end
            end
            TX_DATA: begin
                if (take) begin
                    if (mode_q && upper_byte_valid_in) begin
                        hold_d = data_in; // see RL11
                        left_d = TWO_BYTES;
                    end else begin
                        hold_d = {ZERO_BYTE, data_in[7:0]}; // see RL3
                        left_d = ONE_BYTE;
                    end
                end else if (tick && left_q != NO_BYTES) begin
                    kind_d = LINE_DATA;
                    byte_d = hold_q[7:0];
                    strobe_d = 1'b1;
                    hold_d = {ZERO_BYTE, hold_q[15:8]};
                    left_d = left_q - ONE_BYTE;
                end else if (!transmit_valid && !ready_q && left_q == NO_BYTES) begin
                    state_d = TX_EOP; // see RL5
                end
                // One request per empty holding register; ready never
                // repeats before the taken word has drained
                ready_d = transmit_valid && !ready_q && !take && left_d == NO_BYTES; // see RL9 see RL8
            end
            TX_EOP: begin
                if (tick) begin
                    kind_d = LINE_EOP; // see RL5
                    strobe_d = 1'b1;
                    state_d = TX_IDLE;
                end
            end
            default: begin
                state_d = TX_IDLE;
                left_d = NO_BYTES;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= TX_IDLE;
            kind_q <= LINE_NONE;
            byte_q <= ZERO_BYTE;
            strobe_q <= 1'b0;
            hold_q <= ZERO_WORD;
            left_q <= NO_BYTES;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            byte_q <= byte_d;
            strobe_q <= strobe_d;
            hold_q <= hold_d;
            left_q <= left_d;
            ready_q <= ready_d;
        end
    end

    // In 16-bit mode pin direction follows transmit_valid one cycle late, a short
    // overlap the link controller must allow for at turnaround
    always_comb begin
        if (!mode_q) begin
            oe_n_d = OE_UPPER_OUT; // see RL2 see RL3
            uoe_n_d = 1'b1; // see RL13
        end else if (transmit_valid) begin
            oe_n_d = OE_ALL_IN; // see RL11
            uoe_n_d = 1'b1;
        end else begin
            oe_n_d = OE_ALL_OUT; // see RL12 see RL13
            uoe_n_d = 1'b0;
        end
    end

    // Flags and data pass one register together so they stay aligned
    always_comb begin
        rvalid_d = rx.word_valid; // see RL14
        ractive_d = rx.active; // see RL16
        rerror_d = rx.error; // see RL17
        dout_d = ZERO_WORD; // see RL1
        uout_d = 1'b0;
        if (rx.word_valid) begin
            dout_d = rx.word; // see RL2
            uout_d = mode_q && rx.upper_ok; // see RL12 see RL19
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oe_n_q <= OE_ALL_IN;
            uoe_n_q <= 1'b1;
            dout_q <= ZERO_WORD;
            uout_q <= 1'b0;
            rvalid_q <= 1'b0;
            ractive_q <= 1'b0;
            rerror_q <= 1'b0;
        end else begin
            oe_n_q <= oe_n_d;
            uoe_n_q <= uoe_n_d;
            dout_q <= dout_d;
            uout_q <= uout_d;
            rvalid_q <= rvalid_d;
            ractive_q <= ractive_d;
            rerror_q <= rerror_d;
        end
    end

    assign data_out = dout_q;
    assign data_oe_n = oe_n_q;
    assign upper_byte_valid_out = uout_q;
    assign upper_byte_valid_oe_n = uoe_n_q;
    assign transmit_ready = ready_q;
    assign receive_valid = rvalid_q;
    assign receive_active = ractive_q;
    assign receive_error = rerror_q;
    assign line_tx_kind = kind_q;
    assign line_tx_byte = byte_q;
    assign line_tx_strobe = strobe_q;

endmodule : udp_port
`default_nettype wire

// >>> udp_props.sv
`timescale 1ns/1ps
`default_nettype none
module udp_props #(
    parameter int unsigned BYTE_CLKS_P = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bus_mode_16,
    input wire logic transmit_valid,
    input wire logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe_n,
    input wire logic upper_byte_valid_in,
    input wire logic upper_byte_valid_out,
    input wire logic upper_byte_valid_oe_n,
    input wire logic transmit_ready,
    input wire logic receive_valid,
    input wire logic receive_active,
    input wire logic receive_error,
    input wire udp_pkg::udp_line_kind_t line_tx_kind,
    input wire logic [7:0] line_tx_byte,
    input wire logic line_tx_strobe,
    input wire logic line_rx_active,
    input wire logic line_rx_strobe,
    input wire logic [7:0] line_rx_byte,
    input wire logic line_rx_fault
);
    import udp_pkg::*;
    // Longest wait: eight byte times plus eight clocks of margin
    localparam int MAXW = 8 * BYTE_CLKS_P + 8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    chk_ready_one_cycle: assert property (transmit_ready |=> !transmit_ready) else $error("ready held");
    chk_sync_first: assert property ($rose(transmit_valid) |-> ##[1:MAXW] (line_tx_strobe && line_tx_kind == LINE_SYNC))
        else $error("no sync");
    chk_eop_after: assert property ($fell(transmit_valid) |-> ##[1:MAXW] (line_tx_strobe && line_tx_kind == LINE_EOP))
        else $error("no eop");
    chk_rx_upper_lane: assert property (line_rx_strobe && !bus_mode_16 |-> ##2
        (receive_valid && data_out[15:8] == $past(line_rx_byte, 2))) else $error("rx byte lane");
    chk_data_quiet: assert property (!receive_valid |-> data_out == 16'h0000) else $error("data not quiet");
    chk_active_lag: assert property (line_rx_active |-> ##2 receive_active) else $error("active late");
    chk_valid_in_active: assert property (receive_valid |-> receive_active) else $error("valid outside active");
    chk_error_lag: assert property (line_rx_fault && line_rx_active |-> ##2 (receive_error && receive_active))
        else $error("error timing");
    chk_oe_eight_bit: assert property ($past(nrst, 2) && !bus_mode_16 |-> data_oe_n == 16'h00FF && !upper_byte_valid_out)
        else $error("8-bit drive");
    chk_oe_tx_wide: assert property ($past(nrst, 2) && bus_mode_16 && $past(transmit_valid) |->
        data_oe_n == 16'hFFFF && upper_byte_valid_oe_n) else $error("16-bit tx drive");
    chk_oe_rx_wide: assert property ($past(nrst, 2) && bus_mode_16 && !$past(transmit_valid) |->
        data_oe_n == 16'h0000 && !upper_byte_valid_oe_n) else $error("16-bit rx drive");
endmodule : udp_props
bind udp_port udp_props #(.BYTE_CLKS_P(BYTE_CLKS_P)) props_u (
    .clock(clock),
    .nrst(nrst),
    .bus_mode_16(bus_mode_16),
    .transmit_valid(transmit_valid),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .upper_byte_valid_in(upper_byte_valid_in),
    .upper_byte_valid_out(upper_byte_valid_out),
    .upper_byte_valid_oe_n(upper_byte_valid_oe_n),
    .transmit_ready(transmit_ready),
    .receive_valid(receive_valid),
    .receive_active(receive_active),
    .receive_error(receive_error),
    .line_tx_kind(line_tx_kind),
    .line_tx_byte(line_tx_byte),
    .line_tx_strobe(line_tx_strobe),
    .line_rx_active(line_rx_active),
    .line_rx_strobe(line_rx_strobe),
    .line_rx_byte(line_rx_byte),
    .line_rx_fault(line_rx_fault)
);
`default_nettype wire

// >>> udp_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module udp_link_model (
    input wire logic clock,
    input wire logic transmit_ready,
    input wire logic receive_valid,
    input wire logic [15:0] bus,
    input wire logic bus_uvalid,
    output logic transmit_valid,
    output logic [15:0] drive,
    output logic drive_uvalid
);
    logic [16:0] rx_q[$];
    initial begin
        transmit_valid = 1'b0;
        drive = 16'h5A3C;
        drive_uvalid = 1'b0;
    end
    always @(posedge clock) begin
        if (receive_valid) begin
            rx_q.push_back({bus_uvalid, bus});
        end
    end
    task automatic send(input logic [15:0] w[$], input logic [3:0] uv, output int ok);
        int k;
        int t;
        ok = 1;
        for (k = 0; k < w.size(); k++) begin
            @(negedge clock);
            transmit_valid = 1'b1;
            drive = w[k];
            drive_uvalid = uv[k];
            t = 0;
            while (!transmit_ready && t < 60) begin
                @(negedge clock);
                t++;
            end
            if (t == 60) ok = 0;
        end
        @(negedge clock);
        transmit_valid = 1'b0;
        // Released bus shows inverted data so a stale word cannot pass for a new one
        drive = ~drive;
    endtask : send
endmodule : udp_link_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import udp_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic bus_mode_16 = 1'b0;
    logic transmit_valid, upper_byte_valid_in, upper_byte_valid_out, upper_byte_valid_oe_n, link_uv;
    logic [15:0] data_in, data_out, data_oe_n, link_data;
    logic transmit_ready, receive_valid, receive_active, receive_error, line_tx_strobe;
    udp_line_kind_t line_tx_kind;
    logic [7:0] line_tx_byte;
    logic line_rx_active = 1'b0;
    logic line_rx_strobe = 1'b0;
    logic [7:0] line_rx_byte = 8'h00;
    logic line_rx_fault = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    int err_cycles, act_cycles, ok;
    logic [9:0] tx_q[$];
    always #50 clock = ~clock;
    // Wire level per bit from whichever side has its enable on
    assign data_in = (data_out & ~data_oe_n) | (link_data & data_oe_n);
    assign upper_byte_valid_in = upper_byte_valid_oe_n ? link_uv : upper_byte_valid_out;
    always @(posedge clock) begin
        if (line_tx_strobe) tx_q.push_back({line_tx_kind, line_tx_byte});
        err_cycles += receive_error;
        act_cycles += receive_active;
    end
    udp_port #(.BYTE_CLKS_P(2)) dut_u (
        .clock(clock),
        .nrst(nrst),
        .bus_mode_16(bus_mode_16),
        .transmit_valid(transmit_valid),
        .data_in(data_in),
        .data_out(data_out),
        .data_oe_n(data_oe_n),
        .upper_byte_valid_in(upper_byte_valid_in),
        .upper_byte_valid_out(upper_byte_valid_out),
        .upper_byte_valid_oe_n(upper_byte_valid_oe_n),
        .transmit_ready(transmit_ready),
        .receive_valid(receive_valid),
        .receive_active(receive_active),
        .receive_error(receive_error),
        .line_tx_kind(line_tx_kind),
        .line_tx_byte(line_tx_byte),
        .line_tx_strobe(line_tx_strobe),
        .line_rx_active(line_rx_active),
        .line_rx_strobe(line_rx_strobe),
        .line_rx_byte(line_rx_byte),
        .line_rx_fault(line_rx_fault)
    );
    udp_link_model link_u (.clock(clock), .transmit_ready(transmit_ready), .receive_valid(receive_valid),
        .bus(data_in), .bus_uvalid(upper_byte_valid_in), .transmit_valid(transmit_valid), .drive(link_data),
        .drive_uvalid(link_uv));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    // Bus width only changes under reset, so no transfer is ever in flight
    task automatic do_reset(input logic m);
        @(negedge clock);
        nrst = 1'b0;
        bus_mode_16 = m;
        repeat (2) @(negedge clock);
        check({transmit_ready, receive_valid, receive_active, receive_error, line_tx_strobe, upper_byte_valid_oe_n}, 6'h01);
        check({data_oe_n, line_tx_kind}, {16'hFFFF, LINE_NONE});
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        $display("reset done mode=%0d", m);
    endtask : do_reset
    task automatic tx_check(input logic [15:0] w[$], input logic [3:0] uv, input logic [7:0] b[$]);
        int k;
        tx_q.delete();
        link_u.send(w, uv, ok);
        repeat (16) @(negedge clock);
        check(ok, 1);
        check(tx_q.size(), b.size() + 2);
        check(tx_q[0], {LINE_SYNC, 8'h00});
        for (k = 0; k < b.size(); k++) begin
            check(tx_q[k + 1], {LINE_DATA, b[k]});
        end
        check(tx_q[b.size() + 1], {LINE_EOP, 8'h00});
    endtask : tx_check
    // Bytes arrive back to back, the tightest spacing allowed
    task automatic rx_bytes(input logic [7:0] b[$], input int fault_at);
        int k;
        link_u.rx_q.delete();
        err_cycles = 0;
        act_cycles = 0;
        line_rx_active = 1'b1;
        @(negedge clock);
        for (k = 0; k < b.size(); k++) begin
            line_rx_strobe = 1'b1;
            line_rx_byte = b[k];
            line_rx_fault = (k == fault_at);
            @(negedge clock);
        end
        line_rx_strobe = 1'b0;
        line_rx_fault = 1'b0;
        line_rx_byte = 8'hFF;
        @(negedge clock);
        line_rx_active = 1'b0;
        repeat (6) @(negedge clock);
        // An odd last byte in 16-bit mode flushes one cycle after the line goes quiet
        check(act_cycles, b.size() + 2 + ((bus_mode_16 && (b.size() % 2 == 1)) ? 1 : 0));
    endtask : rx_bytes
    task automatic test_tx8;
        tx_check('{16'hC311, 16'h3C22, 16'hA533}, 4'h0, '{8'h11, 8'h22, 8'h33});
        $display("test_tx8 done");
    endtask : test_tx8
    task automatic test_rx8;
        int k;
        logic [7:0] b[$] = '{8'h81, 8'h7E, 8'h42};
        rx_bytes(b, 1);
        check(err_cycles, 1);
        check(link_u.rx_q.size(), 3);
        for (k = 0; k < 3; k++) begin
            check(link_u.rx_q[k][15:8], b[k]);
        end
        $display("test_rx8 done");
    endtask : test_rx8
    task automatic test_tx16;
        tx_check('{16'hB2A1, 16'hD4C3, 16'h99F5}, 4'h3, '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hF5});
        $display("test_tx16 done");
    endtask : test_tx16
    task automatic test_rx16;
        rx_bytes('{8'h15, 8'hE7, 8'h6B}, 9);
        check(err_cycles, 0);
        check(link_u.rx_q.size(), 2);
        check(link_u.rx_q[0], {1'b1, 16'hE715});
        check({link_u.rx_q[1][16], link_u.rx_q[1][7:0]}, {1'b0, 8'h6B});
        $display("test_rx16 done");
    endtask : test_rx16
    initial begin
        do_reset(1'b0);
        test_tx8();
        test_rx8();
        do_reset(1'b1);
        test_tx16();
        test_rx16();
        give_verdict();
    end
    // About twenty times the expected run, so a stuck handshake ends the run
    initial begin
        repeat (2000) @(posedge clock);
        fail_count++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
